// >>> hw/reb_pkg.sv
package reb_pkg;
	// Subaddresses
	localparam logic [7:0] ADDR_KEY   = 8'h10;
	localparam logic [7:0] ADDR_CONV  = 8'h11;
	localparam logic [7:0] ADDR_SWOUT = 8'h12;
	localparam logic [7:0] ADDR_GCFG  = 8'h13;
	localparam logic [7:0] ADDR_PCFG  = 8'h14;

	// Power-on values and fixed read values
	localparam logic [7:0] RST_CONV   = 8'h00;
	localparam logic [7:0] RST_SWOUT  = 8'h00;
	localparam logic [7:0] RST_GCFG   = 8'h48;
	localparam logic [7:0] RST_PCFG   = 8'hC0;
	localparam logic [7:0] KEY_READ   = 8'h00;
	localparam logic [7:0] READ_NONE  = 8'h00;

	// Writable bits; the rest are reserved and read zero
	localparam logic [7:0] CONV_MASK  = 8'h3F;
	localparam logic [7:0] SWOUT_MASK = 8'h7F;
	localparam logic [7:0] GCFG_MASK  = 8'hFF;
	localparam logic [7:0] PCFG_MASK  = 8'hCF;

	// Field positions
	localparam int CONV6_BIT  = 5;
	localparam int CONV5_BIT  = 4;
	localparam int SEQ_CONV_W = 5;
	localparam int PIN3_BIT   = 6;
	localparam int PIN2_BIT   = 5;
	localparam int PIN1_BIT   = 4;
	localparam int SW3_BIT    = 3;
	localparam int SW2_BIT    = 2;
	localparam int SW1_BIT    = 1;
	localparam int LIN_BIT    = 0;
	localparam int PUSH_BIT   = 6;
	localparam int SEL_BIT    = 5;
	localparam int WARM_BIT   = 7;

	typedef struct packed {
		logic [SEQ_CONV_W-1:0] conv;
		logic                  switch1_on;
		logic                  linear_reg_on;
	} reb_seq_t;

	typedef struct packed {
		logic o;
		logic oe;
	} reb_pad_t;
endpackage

// >>> hw/reb_sync.sv
`timescale 1ns/10ps
module reb_sync #(
	parameter int W      = 2,
	parameter int STAGES = 2
) (
	input  wire logic         clock,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage_q [STAGES];

	generate
		if (STAGES < 2) begin : g_bad
			$error("reb_sync needs at least two stages");
		end
	endgenerate

	// First stage feeds only the next stage
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_q[i] <= '0;
			end
		end else begin
			stage_q[0] <= d;
			for (int i = 1; i < STAGES; i++) begin
				stage_q[i] <= stage_q[i-1];
			end
		end
	end

	assign q = stage_q[STAGES-1];
endmodule

// >>> hw/reb_rail_enable.sv
`timescale 1ns/10ps
module reb_rail_enable #(
	parameter logic [7:0] KEY_XOR     = 8'h7D,
	parameter int         SYNC_STAGES = 2
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	output logic      [7:0]       reg_rdata,
	input  wire logic             factory_seal_flag,
	input  wire logic             seq_update,
	input  wire reb_pkg::reb_seq_t seq_req,
	input  wire logic             pin1_in,
	input  wire logic             pin3_in,
	output reb_pkg::reb_pad_t     pin1_pad,
	output reb_pkg::reb_pad_t     pin2_pad,
	output reb_pkg::reb_pad_t     pin3_pad,
	output logic      [5:0]       conv_on,
	output logic      [2:0]       switch_on,
	output logic                  linear_reg_on,
	output logic                  conv12_warm_reset
);
	logic [7:0] conv_q;
	logic [7:0] swout_q;
	logic [7:0] gcfg_q;
	logic [7:0] pcfg_q;
	logic [7:0] rdata_q;
	logic       unlock_q;
	logic [7:0] unlock_addr_q;
	logic       warm_q;
	logic [1:0] pin_sync;
	logic [7:0] conv_wr;
	logic       key_wr;
	logic       prot_wr;
	logic       pin2_lvl;
	reb_pkg::reb_pad_t pin1_q, pin2_q, pin3_q;

	generate
		if (SYNC_STAGES < 2) begin : g_bad
			$error("SYNC_STAGES must be at least two");
		end
	endgenerate

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		return a == target;
	endfunction

	function automatic logic [7:0] read_value(input logic [7:0] a, input logic [7:0] c,
		input logic [7:0] s, input logic [7:0] g, input logic [7:0] p);
		logic [7:0] v;
		v = reb_pkg::READ_NONE;
		if (hit(a, reb_pkg::ADDR_KEY)) v = reb_pkg::KEY_READ;
		if (hit(a, reb_pkg::ADDR_CONV)) v = c & reb_pkg::CONV_MASK;
		if (hit(a, reb_pkg::ADDR_SWOUT)) v = s & reb_pkg::SWOUT_MASK;
		if (hit(a, reb_pkg::ADDR_GCFG)) v = g;
		if (hit(a, reb_pkg::ADDR_PCFG)) v = p & reb_pkg::PCFG_MASK;
		return v;
	endfunction

	reb_sync #(
		.W      (2),
		.STAGES (SYNC_STAGES)
	) u_sync (
		.clock  (clock),
		.resetn (resetn),
		.d      ({pin3_in, pin1_in}),
		.q      (pin_sync)
	);

	// Unlock arms one write to the subaddress named by the key
	assign key_wr  = reg_wr && hit(reg_addr, reb_pkg::ADDR_KEY);
	assign prot_wr = reg_wr && unlock_q && (reg_addr == unlock_addr_q);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			unlock_q      <= 1'b0;
			unlock_addr_q <= 8'h00;
		end else if (key_wr) begin
			unlock_q      <= 1'b1;
			unlock_addr_q <= reg_wdata ^ KEY_XOR;
		end else if (reg_wr) begin
			// Any other write consumes or cancels the unlock
			unlock_q <= 1'b0;
		end
	end

	// Seal forbids host writes clearing the two backup converters
	always_comb begin
		conv_wr = reg_wdata & reb_pkg::CONV_MASK;
		if (factory_seal_flag) begin
			conv_wr[reb_pkg::CONV6_BIT] = conv_wr[reb_pkg::CONV6_BIT] |
				conv_q[reb_pkg::CONV6_BIT];
			conv_wr[reb_pkg::CONV5_BIT] = conv_wr[reb_pkg::CONV5_BIT] |
				conv_q[reb_pkg::CONV5_BIT];
		end
	end

	// Sequencer assigned last so it wins over a same-cycle host write
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			conv_q <= reb_pkg::RST_CONV;
		end else begin
			if (prot_wr && hit(reg_addr, reb_pkg::ADDR_CONV)) begin
				conv_q <= conv_wr;
			end
			if (seq_update) begin
				conv_q[reb_pkg::SEQ_CONV_W-1:0] <= seq_req.conv;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			swout_q <= reb_pkg::RST_SWOUT;
		end else begin
			if (prot_wr && hit(reg_addr, reb_pkg::ADDR_SWOUT)) begin
				swout_q <= reg_wdata & reb_pkg::SWOUT_MASK;
			end
			if (seq_update) begin
				swout_q[reb_pkg::SW1_BIT] <= seq_req.switch1_on;
				swout_q[reb_pkg::LIN_BIT] <= seq_req.linear_reg_on;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			gcfg_q <= reb_pkg::RST_GCFG;
			pcfg_q <= reb_pkg::RST_PCFG;
		end else if (prot_wr) begin
			if (hit(reg_addr, reb_pkg::ADDR_GCFG)) gcfg_q <= reg_wdata & reb_pkg::GCFG_MASK;
			if (hit(reg_addr, reb_pkg::ADDR_PCFG)) pcfg_q <= reg_wdata & reb_pkg::PCFG_MASK;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= reb_pkg::READ_NONE;
		end else if (reg_rd) begin
			rdata_q <= read_value(reg_addr, conv_q, swout_q, gcfg_q, pcfg_q);
		end
	end

	// Pin one: open-drain output, or released as input
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin1_q <= '0;
		end else begin
			pin1_q.o  <= 1'b0;
			pin1_q.oe <= !gcfg_q[reb_pkg::SEL_BIT] && !swout_q[reb_pkg::PIN1_BIT];
		end
	end

	// Pin two: level from its bit or from pin one; push-pull or open-drain
	always_comb begin
		pin2_lvl = gcfg_q[reb_pkg::SEL_BIT] ? pin_sync[0] : swout_q[reb_pkg::PIN2_BIT];
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin2_q <= '0;
		end else begin
			pin2_q.o  <= gcfg_q[reb_pkg::PUSH_BIT] & pin2_lvl;
			pin2_q.oe <= gcfg_q[reb_pkg::PUSH_BIT] | !pin2_lvl;
		end
	end

	// Pin three: open-drain output, or active-low warm-reset input
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin3_q <= '0;
			warm_q <= 1'b0;
		end else begin
			pin3_q.o  <= 1'b0;
			pin3_q.oe <= !pcfg_q[reb_pkg::WARM_BIT] && !swout_q[reb_pkg::PIN3_BIT];
			warm_q    <= pcfg_q[reb_pkg::WARM_BIT] && !pin_sync[1];
		end
	end

	assign reg_rdata         = rdata_q;
	assign pin1_pad          = pin1_q;
	assign pin2_pad          = pin2_q;
	assign pin3_pad          = pin3_q;
	assign conv_on           = conv_q[5:0];
	assign switch_on         = swout_q[reb_pkg::SW3_BIT:reb_pkg::SW1_BIT];
	assign linear_reg_on     = swout_q[reb_pkg::LIN_BIT];
	assign conv12_warm_reset = warm_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence unlock_for(logic [7:0] target);
		reg_wr && hit(reg_addr, reb_pkg::ADDR_KEY) && ((reg_wdata ^ KEY_XOR) == target);
	endsequence

	// Key write, one idle cycle, then the target write
	sequence unlocked_swout_write;
		unlock_for(reb_pkg::ADDR_SWOUT) ##1 !reg_wr ##1 (reg_wr
			&& hit(reg_addr, reb_pkg::ADDR_SWOUT) && !seq_update);
	endsequence

	key_reads_zero_a: assert property (reg_rd && hit(reg_addr, reb_pkg::ADDR_KEY)
		|=> reg_rdata == reb_pkg::KEY_READ) else $error("key read not zero");

	locked_write_ignored_a: assert property (reg_wr && !unlock_q && !seq_update
		&& hit(reg_addr, reb_pkg::ADDR_CONV) |=> $stable(conv_q))
		else $error("conv register changed without unlock");

	unlock_write_takes_a: assert property (unlocked_swout_write
		|=> swout_q == ($past(reg_wdata) & reb_pkg::SWOUT_MASK))
		else $error("unlocked write lost");

	seal_keeps_six_a: assert property (factory_seal_flag && conv_q[reb_pkg::CONV6_BIT]
		|=> conv_q[reb_pkg::CONV6_BIT]) else $error("sealed converter six off");

	// Sequencer may still turn converter five off for power-down
	seal_keeps_five_a: assert property (factory_seal_flag && conv_q[reb_pkg::CONV5_BIT]
		&& !seq_update |=> conv_q[reb_pkg::CONV5_BIT]) else $error("sealed five off");

	seq_override_a: assert property (seq_update |=> conv_on[4:0] == $past(seq_req.conv)
		&& swout_q[reb_pkg::SW1_BIT] == $past(seq_req.switch1_on)
		&& linear_reg_on == $past(seq_req.linear_reg_on)) else $error("sequencer lost");

	reserved_zero_a: assert property (conv_q[7:6] == 2'b00 && swout_q[7] == 1'b0)
		else $error("reserved bit set");

	pin3_warm_release_a: assert property (pcfg_q[reb_pkg::WARM_BIT] [*2]
		|-> !pin3_pad.oe) else $error("pin three driven in warm mode");

	pin1_select_release_a: assert property (gcfg_q[reb_pkg::SEL_BIT] [*2]
		|-> !pin1_pad.oe) else $error("pin one driven while input");

	pin2_follows_pin1_a: assert property (gcfg_q[reb_pkg::SEL_BIT]
		&& !gcfg_q[reb_pkg::PUSH_BIT] ##1 $stable(gcfg_q)
		|-> pin2_pad.oe == !$past(pin_sync[0])) else $error("output two not following");
endmodule

// >>> testbench/reb_host_model.sv
`timescale 1ns/10ps
module reb_host_model #(
	parameter logic [7:0] KEY_XOR = 8'h7D
) (
	clock,
	reg_wr,
	reg_rd,
	reg_addr,
	reg_wdata,
	reg_rdata
);
	input  wire logic       clock;
	output logic            reg_wr;
	output logic            reg_rd;
	output logic      [7:0] reg_addr;
	output logic      [7:0] reg_wdata;
	input  wire logic [7:0] reg_rdata;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Released lines flip so stale values never pass for live ones
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// One-shot unlock, so every protected write gets its own key
	task automatic pwr(input logic [7:0] a, input logic [7:0] d);
		wr(reb_pkg::ADDR_KEY, a ^ KEY_XOR);
		wr(a, d);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clock);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge clock);
		d = reg_rdata;
	endtask
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic              clock, resetn, reg_wr, reg_rd, seal, seq_update, pin1_in, pin3_in;
	logic        [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic        [5:0] conv_on;
	logic        [2:0] switch_on;
	logic              linear_reg_on, warm;
	reb_pkg::reb_seq_t seq_req;
	reb_pkg::reb_pad_t p1, p2, p3;
	int                num_errors = 0;
	int                checks = 0;
	reb_host_model #(.KEY_XOR(8'h7D)) u_reb_host_model (.clock(clock), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	reb_rail_enable #(.KEY_XOR(8'h7D), .SYNC_STAGES(2)) u_reb_rail_enable (.clock(clock),
		.resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .factory_seal_flag(seal),
		.seq_update(seq_update), .seq_req(seq_req), .pin1_in(pin1_in), .pin3_in(pin3_in),
		.pin1_pad(p1), .pin2_pad(p2), .pin3_pad(p3), .conv_on(conv_on), .switch_on(switch_on),
		.linear_reg_on(linear_reg_on), .conv12_warm_reset(warm));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		u_reb_host_model.rd(a, rv);
		chk($sformatf("reg %h", a), e, rv);
	endtask
	task automatic pads(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
		repeat (4) @(negedge clock);
		chk("pin1", e1, {6'h00, p1});
		chk("pin2", e2, {6'h00, p2});
		chk("pin3", e3, {6'h00, p3});
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic test_reset;
		rchk(reb_pkg::ADDR_KEY, 8'h00);
		rchk(reb_pkg::ADDR_CONV, 8'h00);
		rchk(reb_pkg::ADDR_SWOUT, 8'h00);
		rchk(reb_pkg::ADDR_GCFG, 8'h48);
		rchk(reb_pkg::ADDR_PCFG, 8'hC0);
		rchk(8'h3F, 8'h00);
		pads(8'h01, 8'h01, 8'h00);
		$display("test_reset done");
	endtask
	task automatic test_unlock;
		u_reb_host_model.wr(reb_pkg::ADDR_CONV, 8'h3F);
		rchk(reb_pkg::ADDR_CONV, 8'h00);
		u_reb_host_model.wr(reb_pkg::ADDR_KEY, 8'h5A);
		rchk(reb_pkg::ADDR_KEY, 8'h00);
		u_reb_host_model.pwr(reb_pkg::ADDR_CONV, 8'hFF);
		rchk(reb_pkg::ADDR_CONV, 8'h3F);
		chk("conv_on", 8'h3F, {2'h0, conv_on});
		// Key names one target; a write elsewhere spends it
		u_reb_host_model.wr(reb_pkg::ADDR_KEY, 8'h11 ^ 8'h7D);
		u_reb_host_model.wr(reb_pkg::ADDR_SWOUT, 8'h0F);
		u_reb_host_model.wr(reb_pkg::ADDR_CONV, 8'h00);
		rchk(reb_pkg::ADDR_SWOUT, 8'h00);
		rchk(reb_pkg::ADDR_CONV, 8'h3F);
		$display("test_unlock done");
	endtask
	task automatic test_seal;
		seal = 1'b1;
		u_reb_host_model.pwr(reb_pkg::ADDR_CONV, 8'h00);
		rchk(reb_pkg::ADDR_CONV, 8'h30);
		seal = 1'b0;
		u_reb_host_model.pwr(reb_pkg::ADDR_CONV, 8'h00);
		rchk(reb_pkg::ADDR_CONV, 8'h00);
		$display("test_seal done");
	endtask
	task automatic test_seq;
		@(negedge clock);
		seq_req = 7'h7F;
		seq_update = 1'b1;
		@(negedge clock);
		seq_update = 1'b0;
		seq_req = 7'h00;
		chk("seq conv", 8'h1F, {2'h0, conv_on});
		chk("seq rails", 8'h03, {6'h00, switch_on[0], linear_reg_on});
		rchk(reb_pkg::ADDR_SWOUT, 8'h03);
		$display("test_seq done");
	endtask
	task automatic test_pins;
		u_reb_host_model.pwr(reb_pkg::ADDR_SWOUT, 8'hFF);
		rchk(reb_pkg::ADDR_SWOUT, 8'h7F);
		chk("rails", 8'h0F, {4'h0, switch_on, linear_reg_on});
		pads(8'h00, 8'h03, 8'h00);
		u_reb_host_model.pwr(reb_pkg::ADDR_PCFG, 8'h40);
		u_reb_host_model.pwr(reb_pkg::ADDR_SWOUT, 8'h0F);
		pin3_in = 1'b0;
		pads(8'h01, 8'h01, 8'h01);
		chk("warm off", 8'h00, {7'h00, warm});
		u_reb_host_model.pwr(reb_pkg::ADDR_PCFG, 8'hC0);
		pads(8'h01, 8'h01, 8'h00);
		chk("warm on", 8'h01, {7'h00, warm});
		u_reb_host_model.pwr(reb_pkg::ADDR_GCFG, 8'h68);
		pin1_in = 1'b1;
		pads(8'h00, 8'h03, 8'h00);
		pin1_in = 1'b0;
		pads(8'h00, 8'h01, 8'h00);
		$display("test_pins done");
	endtask
	task automatic test_open_drain;
		u_reb_host_model.pwr(reb_pkg::ADDR_GCFG, 8'h28);
		pads(8'h00, 8'h01, 8'h00);
		pin1_in = 1'b1;
		pads(8'h00, 8'h00, 8'h00);
		u_reb_host_model.pwr(reb_pkg::ADDR_PCFG, 8'h40);
		u_reb_host_model.pwr(reb_pkg::ADDR_SWOUT, 8'h40);
		pads(8'h00, 8'h00, 8'h00);
		$display("test_open_drain done");
	endtask
	initial begin
		resetn = 1'b0;
		seal = 1'b0;
		seq_update = 1'b0;
		seq_req = 7'h00;
		pin1_in = 1'b1;
		pin3_in = 1'b1;
		repeat (16) @(negedge clock);
		resetn = 1'b1;
		test_reset;
		test_unlock;
		test_seal;
		test_seq;
		test_pins;
		test_open_drain;
		give_verdict;
	end
	// Whole run needs under two hundred cycles
	initial begin
		repeat (5000) @(posedge clock);
		num_errors++;
		give_verdict;
	end
endmodule
